// [rtl/t8cp_pkg.sv]
package t8cp_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_COUNTER = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PIN = 8'h14;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int BIT_CMP = 1;
	localparam int BIT_OVF = 0;
	localparam int BIT_PIN_DIR = 0;
	localparam int BIT_PIN_LEVEL = 1;
	localparam int BIT_STROBE = 7;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Prescaler taps
	// ------------------------------------------------------------
	localparam int PSC_W = 10;
	localparam logic [PSC_W-1:0] PSC_DIV8 = 10'h007;
	localparam logic [PSC_W-1:0] PSC_DIV64 = 10'h03f;
	localparam logic [PSC_W-1:0] PSC_DIV256 = 10'h0ff;
	localparam logic [PSC_W-1:0] PSC_DIV1024 = 10'h3ff;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_PHASE = 2'h1,
		MODE_CTC = 2'h2,
		MODE_FAST = 2'h3
	} t8cp_mode_e;

	typedef struct packed {
		logic force_compare_strobe;
		logic waveform_mode_low_bit;
		logic [1:0] compare_output_mode_field;
		logic waveform_mode_high_bit;
		logic [2:0] clock_select_field;
	} t8cp_ctrl_s;

endpackage : t8cp_pkg

// [rtl/t8cp_timer.sv]
`timescale 1ns/1ps
// Summary of operation
// [RQ1] Force strobe acts only in non-PWM modes; software writes it zero in PWM modes.
// [RQ2] Writing force strobe forces an immediate match on the waveform per output mode.
// [RQ3] Forced match sets no flag, raises no interrupt, never clears counter in CTC.
// [RQ4] Force strobe bit always reads back as zero.
// [RQ5] Mode 0 normal, 1 phase PWM, 2 CTC, 3 fast; TOP 0xFF except CTC uses compare.
// [RQ6] Compare loads immediately, at TOP or BOTTOM by mode; overflow at MAX or BOTTOM.
// [RQ7] Nonzero output mode overrides port function; direction bit still enables the driver.
// [RQ8] Non-PWM match: 0 disconnect, 1 toggle, 2 clear, 3 set.
// [RQ9] Fast PWM: 2 clears on match, sets at BOTTOM; 3 reverse; 1 reserved.
// [RQ10] Phase PWM: 2 clears on up match, sets on down match; 3 reverse.
// [RQ11] Fast PWM, compare at TOP with upper mode bit: ignore match, act at BOTTOM.
// [RQ12] Phase PWM, compare at TOP with upper mode bit: ignore match, act at TOP.
// [RQ13] Clock select: stop, 1, /8, /64, /256, /1024, pin falling, pin rising.
// [RQ14] External pin edges count even when the pin is driven as an output.
// [RQ15] Counter readable and writable; a write blocks the match on the next tick.
// [RQ16] Compare value is continuously compared with the counter; match drives flag and output.
// [RQ17] Compare request only when its enable, global enable and flag are all set.
// [RQ18] Overflow request only when its enable, global enable and flag are all set.
// [RQ19] Compare flag set on match; cleared by vector execution or writing one.
// [RQ20] Overflow flag set on overflow; cleared by vector execution or writing one.
// [RQ21] Phase PWM sets overflow flag when direction turns at 0x00.
// [RQ22] Fast PWM counts up to MAX then returns to zero on the next tick.
// [RQ23] Phase PWM counts up to MAX, then counts down on the next tick.
// [RQ24] Control layout: strobe 7, mode low 6, output mode 5:4, mode high 3, select 2:0.
// [RQ25] Writing zero to a flag keeps it; normal mode wraps MAX to zero, setting overflow.
module t8cp_timer
	import t8cp_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic awvalid,
	output logic awready,
	input wire logic [t8cp_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read channels
	input wire logic arvalid,
	output logic arready,
	input wire logic [t8cp_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// CPU interrupt side
	input wire logic global_irq_enable,
	input wire logic cmp_vector_ack,
	input wire logic ovf_vector_ack,
	output logic cmp_irq,
	output logic ovf_irq,
	// Board pins
	input wire logic external_count_pin,
	output logic waveform_output_pin,
	output logic waveform_output_pin_oe
);
	import t8cp_pkg::*;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [7:0] wbyte_r;
	logic wlane_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic wr_fire, wr_hit, wr_ctrl, wr_cnt, wr_cmp, wr_mask, wr_flags, wr_pin;
	logic [7:0] rd_byte;
	logic rd_hit;

	t8cp_ctrl_s ctrl_r;
	logic [7:0] cnt_r, cmp_sw_r, cmp_act_r;
	logic [1:0] mask_r;
	logic cflag_r, oflag_r, pin_dir_r, pin_level_r;

	// Both halves of a write may arrive in either order; the write acts once both are held.
	assign wr_fire = !awready_r && !wready_r && !bvalid_r;
	assign wr_hit = awaddr_r == OFS_CONTROL || awaddr_r == OFS_COUNTER || awaddr_r == OFS_COMPARE ||
		awaddr_r == OFS_MASK || awaddr_r == OFS_FLAGS || awaddr_r == OFS_PIN;
	// Only byte lane 0 carries register data; a write without it changes nothing.
	assign wr_ctrl = wr_fire && wlane_r && awaddr_r == OFS_CONTROL;
	assign wr_cnt = wr_fire && wlane_r && awaddr_r == OFS_COUNTER;
	assign wr_cmp = wr_fire && wlane_r && awaddr_r == OFS_COMPARE;
	assign wr_mask = wr_fire && wlane_r && awaddr_r == OFS_MASK;
	assign wr_flags = wr_fire && wlane_r && awaddr_r == OFS_FLAGS;
	assign wr_pin = wr_fire && wlane_r && awaddr_r == OFS_PIN;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			awaddr_r <= '0;
			wbyte_r <= RST_BYTE;
			wlane_r <= 1'b0;
		end
		else
		begin
			if (awvalid && awready_r)
			begin
				awready_r <= 1'b0;
				awaddr_r <= awaddr;
			end
			else if (bvalid_r && bready)
				awready_r <= 1'b1;
			if (wvalid && wready_r)
			begin
				wready_r <= 1'b0;
				wbyte_r <= wdata[7:0];
				wlane_r <= wstrb[0];
			end
			else if (bvalid_r && bready)
				wready_r <= 1'b1;
			if (wr_fire)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bready)
				bvalid_r <= 1'b0;
		end
	end

	always_comb
	begin
		rd_hit = 1'b1;
		rd_byte = RST_BYTE;
		case (araddr)
			OFS_CONTROL: rd_byte = {1'b0, ctrl_r[6:0]}; // RQ4
			OFS_COUNTER: rd_byte = cnt_r; // RQ15
			OFS_COMPARE: rd_byte = cmp_sw_r;
			OFS_MASK: rd_byte = {6'h00, mask_r};
			OFS_FLAGS: rd_byte = {6'h00, cflag_r, oflag_r};
			OFS_PIN: rd_byte = {6'h00, pin_level_r, pin_dir_r};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end
		else if (arvalid && arready_r)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= {24'h000000, rd_byte};
			rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_r && rready)
		begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	t8cp_mode_e mode;
	logic [1:0] com;
	assign mode = t8cp_mode_e'({ctrl_r.waveform_mode_high_bit, ctrl_r.waveform_mode_low_bit}); // RQ5
	assign com = ctrl_r.compare_output_mode_field;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= '0;
			mask_r <= 2'h0;
			pin_dir_r <= 1'b0;
			pin_level_r <= 1'b0;
			cmp_sw_r <= RST_BYTE;
		end
		else
		begin
			// The strobe is never stored, so it reads as zero.
			if (wr_ctrl)
				ctrl_r <= {1'b0, wbyte_r[6:0]}; // RQ24
			if (wr_mask)
				mask_r <= wbyte_r[1:0];
			if (wr_pin)
			begin
				pin_dir_r <= wbyte_r[BIT_PIN_DIR];
				pin_level_r <= wbyte_r[BIT_PIN_LEVEL];
			end
			if (wr_cmp)
				cmp_sw_r <= wbyte_r;
		end
	end

	// ------------------------------------------------------------
	// Clock select
	// ------------------------------------------------------------
	logic [PSC_W-1:0] psc_r;
	logic ext_meta_r, ext_sync_r, ext_prev_r;
	logic tick;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			psc_r <= '0;
		else
			psc_r <= psc_r + 10'h001;
	end

	// The pin is sampled whatever its direction, so software can drive counting.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
			ext_prev_r <= 1'b0;
		end
		else
		begin
			ext_meta_r <= external_count_pin; // RQ14
			ext_sync_r <= ext_meta_r;
			ext_prev_r <= ext_sync_r;
		end
	end

	always_comb
	begin
		case (ctrl_r.clock_select_field) // RQ13
			3'h1: tick = 1'b1;
			3'h2: tick = (psc_r & PSC_DIV8) == PSC_DIV8;
			3'h3: tick = (psc_r & PSC_DIV64) == PSC_DIV64;
			3'h4: tick = (psc_r & PSC_DIV256) == PSC_DIV256;
			3'h5: tick = psc_r == PSC_DIV1024;
			3'h6: tick = ext_prev_r && !ext_sync_r;
			3'h7: tick = !ext_prev_r && ext_sync_r;
			default: tick = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Counter, compare and waveform
	// ------------------------------------------------------------
	logic dir_down_r, block_r, oc_r;
	logic is_pwm, at_max, match_raw, match_ev, ignore_match, force_ev, ovf_ev;
	logic [7:0] top;
	t8cp_ctrl_s ctrl_wr_val;

	// The strobe travels with the byte that carries it, so its mode and action come from that byte.
	assign ctrl_wr_val = t8cp_ctrl_s'(wbyte_r);

	assign is_pwm = mode == MODE_PHASE || mode == MODE_FAST;
	assign top = mode == MODE_CTC ? cmp_act_r : CNT_MAX; // RQ5
	assign at_max = cnt_r == CNT_MAX;
	assign match_raw = cnt_r == cmp_act_r; // RQ16
	assign ignore_match = is_pwm && cmp_act_r == CNT_MAX && com[1]; // RQ11 RQ12
	assign match_ev = tick && match_raw && !block_r; // RQ15
	assign force_ev = wr_ctrl && ctrl_wr_val.force_compare_strobe && !ctrl_wr_val.waveform_mode_low_bit; // RQ1
	assign ovf_ev = tick && (mode == MODE_PHASE ? dir_down_r && cnt_r == CNT_BOTTOM : at_max); // RQ6 RQ21

	// A counter write wins over a tick in the same cycle and blocks the next match.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_r <= CNT_BOTTOM;
			dir_down_r <= 1'b0;
			block_r <= 1'b0;
		end
		else if (wr_cnt)
		begin
			cnt_r <= wbyte_r;
			block_r <= 1'b1; // RQ15
		end
		else if (tick)
		begin
			block_r <= 1'b0;
			case (mode)
				MODE_CTC:
				begin
					dir_down_r <= 1'b0;
					cnt_r <= cnt_r == top ? CNT_BOTTOM : cnt_r + 8'h01; // RQ5
				end
				MODE_PHASE:
				begin
					if (!dir_down_r && at_max)
					begin
						dir_down_r <= 1'b1; // RQ23
						cnt_r <= cnt_r - 8'h01;
					end
					else if (dir_down_r && cnt_r == CNT_BOTTOM)
					begin
						dir_down_r <= 1'b0;
						cnt_r <= cnt_r + 8'h01;
					end
					else
						cnt_r <= dir_down_r ? cnt_r - 8'h01 : cnt_r + 8'h01;
				end
				default:
				begin
					// A stale down direction left by phase mode would stall the fast compare buffer.
					dir_down_r <= 1'b0;
					cnt_r <= cnt_r + 8'h01; // RQ22 RQ25
				end
			endcase
		end
	end

	// PWM modes double-buffer the compare value so a period never sees a half update.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cmp_act_r <= RST_BYTE;
		else if (!is_pwm)
			cmp_act_r <= cmp_sw_r; // RQ6
		else if (tick && at_max && !dir_down_r)
			cmp_act_r <= cmp_sw_r; // RQ6
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			oc_r <= 1'b0;
		else if (force_ev)
		begin
			case (ctrl_wr_val.compare_output_mode_field) // RQ2
				2'h1: oc_r <= !oc_r;
				2'h2: oc_r <= 1'b0;
				2'h3: oc_r <= 1'b1;
				default: oc_r <= oc_r;
			endcase
		end
		else if (mode == MODE_FAST && com[1] && tick && at_max)
			oc_r <= !com[0]; // RQ9 RQ11
		else if (mode == MODE_PHASE && ignore_match && tick && at_max && !dir_down_r)
			oc_r <= !com[0]; // RQ12
		else if (match_ev && !ignore_match)
		begin
			case (mode)
				MODE_FAST: oc_r <= com[1] ? com[0] : oc_r; // RQ9
				MODE_PHASE: oc_r <= com[1] ? (dir_down_r ? !com[0] : com[0]) : oc_r; // RQ10
				default:
				begin
					case (com) // RQ8
						2'h1: oc_r <= !oc_r;
						2'h2: oc_r <= 1'b0;
						2'h3: oc_r <= 1'b1;
						default: oc_r <= oc_r;
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			waveform_output_pin <= 1'b0;
			waveform_output_pin_oe <= 1'b0;
		end
		else
		begin
			waveform_output_pin <= com != 2'h0 ? oc_r : pin_level_r; // RQ7
			waveform_output_pin_oe <= pin_dir_r; // RQ7
		end
	end

	// ------------------------------------------------------------
	// Flags and interrupt requests
	// ------------------------------------------------------------
	// A new event wins over a clear arriving in the same cycle.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cflag_r <= 1'b0;
			oflag_r <= 1'b0;
		end
		else
		begin
			if (match_ev)
				cflag_r <= 1'b1; // RQ3 RQ19
			else if (cmp_vector_ack || (wr_flags && wbyte_r[BIT_CMP]))
				cflag_r <= 1'b0; // RQ19 RQ25
			if (ovf_ev)
				oflag_r <= 1'b1; // RQ20
			else if (ovf_vector_ack || (wr_flags && wbyte_r[BIT_OVF]))
				oflag_r <= 1'b0; // RQ20 RQ25
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmp_irq <= 1'b0;
			ovf_irq <= 1'b0;
		end
		else
		begin
			cmp_irq <= mask_r[BIT_CMP] && global_irq_enable && cflag_r; // RQ17
			ovf_irq <= mask_r[BIT_OVF] && global_irq_enable && oflag_r; // RQ18
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_force_no_flag;
		force_ev && !match_ev && !cflag_r |=> !cflag_r;
	endproperty
	a_force_no_flag: assert property (p_force_no_flag) else $error("forced match set the flag"); // RQ3

	property p_force_toggle;
		force_ev && ctrl_wr_val.compare_output_mode_field == 2'h1 |=> oc_r != $past(oc_r);
	endproperty
	a_force_toggle: assert property (p_force_toggle) else $error("forced toggle missing"); // RQ2

	property p_strobe_reads_zero;
		arvalid && arready_r && araddr == OFS_CONTROL |=> rvalid_r && !rdata_r[BIT_STROBE];
	endproperty
	a_strobe_reads_zero: assert property (p_strobe_reads_zero) else $error("strobe read as one"); // RQ4

	property p_ctc_clear;
		tick && mode == MODE_CTC && cnt_r == cmp_act_r && !wr_cnt |=> cnt_r == CNT_BOTTOM;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("CTC did not clear at TOP"); // RQ5

	property p_fast_wrap;
		tick && mode == MODE_FAST && at_max && !wr_cnt |=> cnt_r == CNT_BOTTOM && oflag_r;
	endproperty
	a_fast_wrap: assert property (p_fast_wrap) else $error("fast PWM wrap wrong"); // RQ22

	property p_phase_turn;
		tick && mode == MODE_PHASE && at_max && !dir_down_r && !wr_cnt |=> cnt_r == 8'hfe && dir_down_r;
	endproperty
	a_phase_turn: assert property (p_phase_turn) else $error("phase PWM turn wrong"); // RQ23

	property p_phase_ovf;
		tick && mode == MODE_PHASE && dir_down_r && cnt_r == CNT_BOTTOM && !wr_cnt |=> oflag_r && !dir_down_r;
	endproperty
	a_phase_ovf: assert property (p_phase_ovf) else $error("phase PWM overflow missing"); // RQ21

	property p_block;
		block_r && !cflag_r |=> !cflag_r;
	endproperty
	a_block: assert property (p_block) else $error("blocked match set the flag"); // RQ15

	property p_gie_gate;
		!global_irq_enable |=> !cmp_irq && !ovf_irq;
	endproperty
	a_gie_gate: assert property (p_gie_gate) else $error("request without global enable"); // RQ17 RQ18

	property p_w1c_zero;
		cflag_r && wr_flags && !wbyte_r[BIT_CMP] && !cmp_vector_ack |=> cflag_r;
	endproperty
	a_w1c_zero: assert property (p_w1c_zero) else $error("zero write cleared flag"); // RQ25

	property p_override;
		com != 2'h0 ##1 com != 2'h0 |-> waveform_output_pin == $past(oc_r);
	endproperty
	a_override: assert property (p_override) else $error("pin not overridden"); // RQ7

	c_fast_match: cover property (mode == MODE_FAST && match_ev && !ignore_match);
	c_phase_ovf: cover property (mode == MODE_PHASE && ovf_ev);
	c_force: cover property (force_ev);
	c_ext_tick: cover property (ctrl_r.clock_select_field == 3'h7 && tick);

endmodule : t8cp_timer

// [tb/t8cp_board.sv]
`timescale 1ns/1ps
module t8cp_board (
	// Clock
	input wire logic aclk,
	// Waveform pin seen on the board
	input wire logic pin,
	input wire logic pin_oe,
	// External count source
	output logic count_pin
);

	initial count_pin = 1'b0;

	// Each level is held three cycles so the sampler never misses an edge.
	task automatic pulses(input int n);
		repeat (n)
		begin
			repeat (3) @(posedge aclk);
			count_pin <= 1'b1;
			repeat (3) @(posedge aclk);
			count_pin <= 1'b0;
		end
	endtask : pulses

	// The pin only counts as high while its driver is enabled.
	task automatic measure(input int len, output int high);
		high = 0;
		repeat (len)
		begin
			@(posedge aclk);
			if (pin_oe === 1'b1 && pin === 1'b1)
				high++;
		end
	endtask : measure

endmodule : t8cp_board

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
	import t8cp_pkg::*;

	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, gie, cack, oack;
	logic awready, wready, bvalid, arready, rvalid, cmp_irq, ovf_irq, wpin, wpin_oe, cpin;
	logic [7:0] awaddr, araddr, c;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [67:0] expq[$];
	logic [67:0] e;
	logic [15:0] ft[4] = '{16'h9001, 16'h9000, 16'hb001, 16'ha000};
	logic [7:0] pm[4] = '{8'h69, 8'h79, 8'h61, 8'h71};
	int dv[4] = '{8, 64, 256, 1024};
	int failures, cmp_count, hi, ex, per;

	t8cp_timer uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .global_irq_enable(gie),
		.cmp_vector_ack(cack), .ovf_vector_ack(oack), .cmp_irq(cmp_irq), .ovf_irq(ovf_irq),
		.external_count_pin(cpin), .waveform_output_pin(wpin), .waveform_output_pin_oe(wpin_oe));

	t8cp_board board (.aclk(aclk), .pin(wpin), .pin_oe(wpin_oe), .count_pin(cpin));

	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
		bit ad, wd;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ad = 1'b0;
		wd = 1'b0;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (!ad && awready)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready)
			begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		// The response ready stays high between transfers, so it never changes twice in one step.
		do @(posedge aclk); while (!bvalid);
		check("bresp", {32'h0, bresp}, {32'h0, er});
	endtask : wr

	// Reads only queue their expectation; the monitor below does the comparing.
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m = 8'hff,
		input logic [1:0] er = RESP_OKAY);
		expq.push_back({2'h3, 24'hffffff, m, er, 24'h000000, d & m});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
	endtask : rd

	task automatic irqchk(input logic [1:0] x);
		repeat (3) @(posedge aclk);
		check("irq", {32'h0, cmp_irq, ovf_irq}, {32'h0, x});
	endtask : irqchk

	task automatic ends(input string name);
		$display("test %s finished", name);
	endtask : ends

	always @(posedge aclk)
		if (rvalid === 1'b1 && rready === 1'b1)
		begin
			e = expq.pop_front();
			check("rdata", {rresp, rdata} & e[67:34], e[33:0]);
		end

	initial
	begin
		#900000;
		failures++;
		$display("watchdog expired");
		final_report();
	end

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, gie, cack, oack} = 9'h000;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		failures = 0;
		cmp_count = 0;
		hi = $urandom(84);
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 6; i++)
			rd(8'(i * 4), 8'h00);
		rd(8'h1c, 8'h00, 8'hff, RESP_SLVERR);
		wr(8'h18, 8'h55, RESP_SLVERR);
		ends("reset");
		wr(OFS_PIN, 8'h01);
		foreach (ft[i])
		begin
			wr(OFS_CONTROL, ft[i][15:8]);
			repeat (3) @(posedge aclk);
			check("pin", {33'h0, wpin}, {33'h0, ft[i][0]});
		end
		check("oe", {33'h0, wpin_oe}, 34'h1);
		wr(OFS_CONTROL, 8'hf8);
		repeat (3) @(posedge aclk);
		check("pin", {33'h0, wpin}, 34'h0);
		c = 8'($urandom);
		wr(OFS_COUNTER, c);
		wr(OFS_CONTROL, 8'h98);
		rd(OFS_COUNTER, c);
		rd(OFS_FLAGS, 8'h00);
		rd(OFS_CONTROL, 8'h18);
		ends("force");
		wr(OFS_COUNTER, 8'h00);
		wr(OFS_COMPARE, 8'h00);
		wr(OFS_CONTROL, 8'h01);
		repeat (300) @(posedge aclk);
		wr(OFS_CONTROL, 8'h00);
		rd(OFS_FLAGS, 8'h03);
		wr(OFS_FLAGS, 8'h00);
		rd(OFS_FLAGS, 8'h03);
		wr(OFS_MASK, 8'h03);
		gie <= 1'b1;
		irqchk(2'b11);
		gie <= 1'b0;
		irqchk(2'b00);
		gie <= 1'b1;
		oack <= 1'b1;
		@(posedge aclk);
		oack <= 1'b0;
		irqchk(2'b10);
		wr(OFS_FLAGS, 8'h02);
		rd(OFS_FLAGS, 8'h00);
		wr(OFS_COUNTER, 8'h00);
		c = 8'(1 + $urandom % 200);
		wr(OFS_COMPARE, c);
		wr(OFS_CONTROL, 8'h09);
		repeat (300) @(posedge aclk);
		wr(OFS_CONTROL, 8'h08);
		rd(OFS_FLAGS, 8'h02);
		irqchk(2'b10);
		cack <= 1'b1;
		@(posedge aclk);
		cack <= 1'b0;
		irqchk(2'b00);
		wr(OFS_MASK, 8'h00);
		ends("flags");
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_COUNTER, 8'h00);
			wr(OFS_CONTROL, 8'(i + 2));
			repeat (dv[i] * 9 / 2) @(posedge aclk);
			wr(OFS_CONTROL, 8'h00);
			rd(OFS_COUNTER, 8'h04, 8'hfe);
		end
		wr(OFS_COUNTER, 8'h00);
		wr(OFS_CONTROL, 8'h07);
		board.pulses(5);
		repeat (6) @(posedge aclk);
		rd(OFS_COUNTER, 8'h05);
		wr(OFS_CONTROL, 8'h06);
		board.pulses(3);
		repeat (6) @(posedge aclk);
		rd(OFS_COUNTER, 8'h08);
		ends("clock select");
		// The high time over whole periods does not depend on where the window starts.
		c = 8'(1 + $urandom % 250);
		for (int k = 0; k < 2; k++)
		begin
			wr(OFS_COMPARE, k ? 8'hff : c);
			foreach (pm[i])
			begin
				wr(OFS_CONTROL, pm[i]);
				per = pm[i][3] ? 256 : 510;
				repeat (2 * per + 10) @(posedge aclk);
				board.measure(10 * per, hi);
				ex = pm[i][3] ? 10 * ((k ? 255 : int'(c)) + 1) : 20 * (k ? 255 : int'(c));
				if (pm[i][4])
					ex = 10 * per - ex;
				check("duty", 34'(hi), 34'(ex));
			end
		end
		ends("pwm");
		repeat (4) @(posedge aclk);
		final_report();
	end

endmodule : tb
